// >>> common/line_driver_test_pkg.sv
// Constants shared by the line driver test and self-test extension logic.
// Assumes a 20 MHz system clock and a plain address/strobe register port.
package line_driver_test_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register addresses on the register port.
  localparam logic [7:0] REG_EXT_ADDR = 8'h1B;
  localparam logic [7:0] REG_IRQ_STAT_ADDR = 8'h30;
  localparam logic [7:0] REG_IRQ_MASK_ADDR = 8'h31;
  localparam logic [7:0] REG_CTRL_ADDR = 8'h32;

  // Field positions of driver_test_selftest_ext.
  localparam int TALLY_LSB = 8;
  localparam int TALLY_MSB = 15;
  localparam int ENDLESS_BIT = 5;
  localparam int PAT_ON_BIT = 4;
  localparam int SPACING_BIT = 2;
  localparam int PICK_LSB = 0;
  localparam int PICK_MSB = 1;

  // Field positions of the control and interrupt registers.
  localparam int GUARD_OFF_BIT = 0;
  localparam int IRQ_SAT_BIT = 0;
  localparam int IRQ_CUT_BIT = 1;
  localparam int IRQ_W = 2;

  // Reset values and the tally maximum.
  localparam logic [7:0] EXT_LOW_RESET = 8'h00;
  localparam logic [7:0] TALLY_RESET = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hFF;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;

  // Pattern selector codes.
  localparam logic [1:0] PICK_FORM_A = 2'h0;
  localparam logic [1:0] PICK_FORM_B = 2'h1;
  localparam logic [1:0] PICK_PULSE = 2'h2;
  localparam logic [1:0] PICK_TONE = 2'h3;

  // Timing.
  localparam int CLK_PERIOD_NS = 50;
  localparam int GAP_SHORT_NS = 10000;
  localparam int GAP_LONG_NS = 15000;
  localparam int JAB_LIMIT_NS = 20000000;
  localparam logic [15:0] GAP_SHORT_CYC =
    16'((GAP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] GAP_LONG_CYC =
    16'((GAP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int JAB_LIMIT_CYC = JAB_LIMIT_NS / CLK_PERIOD_NS;
  localparam logic [15:0] SEQ_CYC = 16'h0080;
  localparam logic [15:0] FORM_A_CYC = 16'h0004;
  localparam logic [15:0] FORM_B_CYC = 16'h0006;
  localparam logic [15:0] PULSE_CYC = 16'h0002;

endpackage

// >>> hw/line_driver_test.sv
// Line driver test patterns, continuous self-test and nibble error tally.
// Assumes all inputs come from logic on clk and one register port master.
//
// What this block does
// R01 - Count each errored nibble during self-test
// R02 - Clear tally when self-test restarts
// R03 - Tally saturates at maximum, never wraps
// R04 - Continuous mode sends gapless pseudo-random data
// R05 - Continuous mode needs self-test running too
// R06 - Software disables overlength guard before continuous
// R07 - Pattern enable turns pattern generation on
// R08 - Spacing bit picks 15 or 10 microseconds
// R09 - Selector picks form A, B, pulses, tone
// R10 - Guard off disables the overlength transmit cutoff
// R11 - Tally field ignores writes
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module line_driver_test #(
  parameter int unsigned JAB_CYC = line_driver_test_pkg::JAB_LIMIT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [line_driver_test_pkg::ADDR_W-1:0] addr,
  input wire logic [line_driver_test_pkg::DATA_W-1:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [line_driver_test_pkg::DATA_W-1:0] rdData,
  input wire logic selftestRun,
  input wire logic nibbleValid,
  input wire logic nibbleErr,
  output logic txLine,
  output logic txEnable,
  output logic irq
);
  import line_driver_test_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DATA, ST_TAIL, ST_PULSE, ST_TONE, ST_GAP, ST_CONT
  } state_t;

  state_t stateQ, stateD;
  logic [15:0] cntQ, cntD;
  logic halfQ, halfD;
  logic [14:0] prbsQ, prbsD;
  logic [7:0] extQ, extD;
  logic [7:0] tallyQ, tallyD;
  logic runPrevQ;
  logic guardOffQ, guardOffD;
  logic [IRQ_W-1:0] statQ, statD, maskQ, maskD;
  logic [23:0] jabCntQ, jabCntD;
  logic cutQ, cutD;
  logic [DATA_W-1:0] rdDataD;
  logic txLineD, txEnableD, irqD;
  logic rawLine, rawEn;
  logic restart, tallyInc, satEvent, cutEvent;
  logic patOn, endless, contRun, spacing;
  logic [1:0] pick;
  logic [15:0] gapCyc;

  assign patOn = extQ[PAT_ON_BIT];
  assign endless = extQ[ENDLESS_BIT];
  assign spacing = extQ[SPACING_BIT];
  assign pick = extQ[PICK_MSB:PICK_LSB];
  // R05 continuous gated by run.
  assign contRun = endless && selftestRun;
  // R08 gap length select.
  assign gapCyc = spacing ? GAP_LONG_CYC : GAP_SHORT_CYC;

  // Pattern and continuous transmit sequencer.
  always_comb begin
    stateD = stateQ;
    cntD = cntQ;
    halfD = ~halfQ;
    prbsD = prbsQ;
    rawLine = 1'b0;
    rawEn = 1'b0;
    case (stateQ)
      ST_IDLE: begin
        halfD = 1'b0;
        // R04 enter continuous transmit.
        if (contRun) begin
          stateD = ST_CONT;
        // R07 pattern enable starts.
        end else if (patOn) begin
          // R09 selector decode.
          case (pick)
            PICK_FORM_A, PICK_FORM_B: begin
              stateD = ST_DATA;
              cntD = SEQ_CYC - 16'h0001;
            end
            PICK_PULSE: begin
              stateD = ST_PULSE;
              cntD = PULSE_CYC - 16'h0001;
            end
            default: stateD = ST_TONE;
          endcase
        end
      end
      ST_DATA: begin
        rawEn = 1'b1;
        rawLine = halfQ ? prbsQ[14] : ~prbsQ[14];
        if (halfQ) begin
          prbsD = {prbsQ[13:0], prbsQ[14] ^ prbsQ[13]};
        end
        cntD = cntQ - 16'h0001;
        if (cntQ == 16'h0000) begin
          stateD = ST_TAIL;
          cntD = ((pick == PICK_FORM_B) ? FORM_B_CYC : FORM_A_CYC)
                 - 16'h0001;
        end
      end
      ST_TAIL, ST_PULSE: begin
        rawEn = 1'b1;
        rawLine = 1'b1;
        cntD = cntQ - 16'h0001;
        if (cntQ == 16'h0000) begin
          stateD = ST_GAP;
          cntD = gapCyc - 16'h0001;
        end
      end
      ST_GAP: begin
        cntD = cntQ - 16'h0001;
        if (cntQ == 16'h0000) begin
          stateD = ST_IDLE;
        end
      end
      ST_TONE: begin
        // R09 constant Manchester ones.
        rawEn = 1'b1;
        rawLine = halfQ;
        if (pick != PICK_TONE) begin
          stateD = ST_IDLE;
        end
      end
      ST_CONT: begin
        // R04 gapless pseudo-random data.
        rawEn = 1'b1;
        rawLine = halfQ ? prbsQ[14] : ~prbsQ[14];
        if (halfQ) begin
          prbsD = {prbsQ[13:0], prbsQ[14] ^ prbsQ[13]};
        end
        if (!contRun) begin
          stateD = ST_IDLE;
        end
      end
      default: stateD = ST_IDLE;
    endcase
    // R07 pattern disable stops.
    if (stateQ != ST_IDLE && stateQ != ST_CONT && (!patOn || contRun)) begin
      stateD = ST_IDLE;
    end
  end

  // Overlength cutoff, tally and register file.
  always_comb begin
    jabCntD = jabCntQ;
    cutD = cutQ;
    cutEvent = 1'b0;
    // R10 guard off bypasses cutoff.
    if (guardOffQ || !rawEn) begin
      jabCntD = 24'h000000;
      cutD = 1'b0;
    end else if (!cutQ) begin
      if (jabCntQ == 24'(JAB_CYC - 1)) begin
        cutD = 1'b1;
        cutEvent = 1'b1;
      end else begin
        jabCntD = jabCntQ + 24'h000001;
      end
    end
    txEnableD = rawEn && !cutD;
    txLineD = rawLine && txEnableD;

    restart = selftestRun && !runPrevQ;
    tallyInc = selftestRun && nibbleValid && nibbleErr;
    tallyD = tallyQ;
    satEvent = 1'b0;
    // R02 restart clears tally.
    if (restart) begin
      tallyD = TALLY_RESET;
    // R01 count errored nibbles, R03 saturate.
    end else if (tallyInc && tallyQ != TALLY_MAX) begin
      tallyD = tallyQ + 8'h01;
      satEvent = (tallyQ == TALLY_MAX - 8'h01);
    end

    extD = extQ;
    maskD = maskQ;
    guardOffD = guardOffQ;
    // R11 writes reach low byte only.
    if (wrStb) begin
      case (addr)
        REG_EXT_ADDR: extD = wrData[7:0];
        REG_IRQ_MASK_ADDR: maskD = wrData[IRQ_W-1:0];
        REG_CTRL_ADDR: guardOffD = wrData[GUARD_OFF_BIT];
        default: ;
      endcase
    end

    rdDataD = '0;
    statD = statQ;
    if (rdStb) begin
      case (addr)
        REG_EXT_ADDR: rdDataD = {tallyQ, extQ};
        REG_IRQ_STAT_ADDR: begin
          rdDataD[IRQ_W-1:0] = statQ;
          statD = IRQ_RESET;
        end
        REG_IRQ_MASK_ADDR: rdDataD[IRQ_W-1:0] = maskQ;
        REG_CTRL_ADDR: rdDataD[GUARD_OFF_BIT] = guardOffQ;
        default: rdDataD = '0;
      endcase
    end
    // Events set after the read clear so a coincident event is kept.
    if (satEvent) begin
      statD[IRQ_SAT_BIT] = 1'b1;
    end
    if (cutEvent) begin
      statD[IRQ_CUT_BIT] = 1'b1;
    end
    irqD = |(statD & maskD);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= ST_IDLE;
      cntQ <= 16'h0000;
      halfQ <= 1'b0;
      prbsQ <= PRBS_SEED;
      extQ <= EXT_LOW_RESET;
      tallyQ <= TALLY_RESET;
      runPrevQ <= 1'b0;
      guardOffQ <= CTRL_RESET;
      statQ <= IRQ_RESET;
      maskQ <= IRQ_RESET;
      jabCntQ <= 24'h000000;
      cutQ <= 1'b0;
      rdData <= '0;
      txLine <= 1'b0;
      txEnable <= 1'b0;
      irq <= 1'b0;
    end else begin
      stateQ <= stateD;
      cntQ <= cntD;
      halfQ <= halfD;
      prbsQ <= prbsD;
      extQ <= extD;
      tallyQ <= tallyD;
      runPrevQ <= selftestRun;
      guardOffQ <= guardOffD;
      statQ <= statD;
      maskQ <= maskD;
      jabCntQ <= jabCntD;
      cutQ <= cutD;
      rdData <= rdDataD;
      txLine <= txLineD;
      txEnable <= txEnableD;
      irq <= irqD;
    end
  end

  // R01 tally increments by one.
  property p_tally_count;
    @(posedge clk) disable iff (sys_rst)
    (tallyInc && !restart && tallyQ != TALLY_MAX)
      |=> tallyQ == $past(tallyQ) + 8'h01;
  endproperty
  a_tally_count: assert property (p_tally_count) // R01
    else $error("tally did not count an errored nibble");

  // R02 restart clears tally.
  property p_tally_clear;
    @(posedge clk) disable iff (sys_rst)
    (selftestRun && !runPrevQ) |=> tallyQ == TALLY_RESET;
  endproperty
  a_tally_clear: assert property (p_tally_clear) // R02
    else $error("tally not cleared at self-test restart");

  // R03 tally holds at maximum.
  property p_tally_sat;
    @(posedge clk) disable iff (sys_rst)
    (tallyQ == TALLY_MAX && !restart) |=> tallyQ == TALLY_MAX;
  endproperty
  a_tally_sat: assert property (p_tally_sat) // R03
    else $error("tally wrapped past its maximum");

  // R04 continuous mode keeps driving.
  property p_cont_tx;
    @(posedge clk) disable iff (sys_rst)
    (contRun && guardOffQ) [*4] |-> txEnable;
  endproperty
  a_cont_tx: assert property (p_cont_tx) // R04
    else $error("continuous transmit has a gap");

  // R05 continuous state only with self-test running.
  property p_cont_run;
    @(posedge clk) disable iff (sys_rst)
    stateQ == ST_CONT |-> $past(contRun);
  endproperty
  a_cont_run: assert property (p_cont_run) // R05
    else $error("continuous transmit without self-test run");

  // R07 pattern off silences driver.
  property p_pat_off;
    @(posedge clk) disable iff (sys_rst)
    (!patOn && !contRun) [*3] |-> !txEnable;
  endproperty
  a_pat_off: assert property (p_pat_off) // R07
    else $error("driver active with patterns disabled");

  // R08 gap length loaded from spacing bit.
  property p_gap_len;
    @(posedge clk) disable iff (sys_rst)
    (stateQ == ST_GAP && $past(stateQ) != ST_GAP)
      |-> cntQ == $past(gapCyc) - 16'h0001;
  endproperty
  a_gap_len: assert property (p_gap_len) // R08
    else $error("wrong gap length loaded");

  // R09 link pulse selection.
  sequence s_pulse_pick;
    stateQ == ST_IDLE && patOn && !contRun && pick == PICK_PULSE;
  endsequence
  sequence s_pulse_out;
    stateQ == ST_PULSE ##1 txEnable && txLine;
  endsequence
  property p_pick_pulse;
    @(posedge clk) disable iff (sys_rst)
    s_pulse_pick ##1 (patOn && !contRun && !cutD) |-> s_pulse_out;
  endproperty
  a_pick_pulse: assert property (p_pick_pulse) // R09
    else $error("link pulse not sent for pulse selection");

  // R09 tone selection.
  property p_pick_tone;
    @(posedge clk) disable iff (sys_rst)
    (stateQ == ST_IDLE && patOn && !contRun && pick == PICK_TONE)
      |=> stateQ == ST_TONE;
  endproperty
  a_pick_tone: assert property (p_pick_tone) // R09
    else $error("tone not selected");

  // R10 guard off never cuts.
  property p_guard_off;
    @(posedge clk) disable iff (sys_rst)
    guardOffQ [*2] |-> !cutQ;
  endproperty
  a_guard_off: assert property (p_guard_off) // R10
    else $error("cutoff applied with guard off");

  // R11 tally stable without self-test.
  property p_tally_wr;
    @(posedge clk) disable iff (sys_rst)
    (wrStb && addr == REG_EXT_ADDR && !selftestRun) |=> $stable(tallyQ);
  endproperty
  a_tally_wr: assert property (p_tally_wr) // R11
    else $error("write changed the tally");

endmodule // line_driver_test
`default_nettype wire

// >>> sim/line_monitor.sv
// Line-side monitor standing in for the remote station on the pair.
// Assumes txEnable is registered on clk by the block under test.
`timescale 1ns/1ps
`default_nettype none

module line_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic txEnable,
  output logic [15:0] burstLen,
  output logic [15:0] gapLen
);
  logic prev_q;
  logic [15:0] cnt_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
      cnt_q <= 16'h0000;
      burstLen <= 16'h0000;
      gapLen <= 16'h0000;
    end else begin
      prev_q <= txEnable;
      if (txEnable != prev_q) begin
        cnt_q <= 16'h0001;
        if (prev_q) begin
          burstLen <= cnt_q;
        end else begin
          gapLen <= cnt_q;
        end
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule // line_monitor

`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the line driver test logic.
// Assumes the line monitor and the shared package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import line_driver_test_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic selftestRun = 1'b0;
  logic nibbleValid = 1'b0;
  logic nibbleErr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wrData = 16'h0000;
  logic [15:0] rdData, burstLen, gapLen, v;
  logic txLine, txEnable, irq;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  line_driver_test #(.JAB_CYC(50)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .selftestRun(selftestRun), .nibbleValid(nibbleValid),
    .nibbleErr(nibbleErr), .txLine(txLine), .txEnable(txEnable), .irq(irq));

  line_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .txEnable(txEnable),
    .burstLen(burstLen), .gapLen(gapLen));

  task automatic finish_test;
    $display("TB: %0d checks, %0d errors", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 d = rdData;
  endtask

  task automatic nib(input logic e, input int n);
    repeat (n) begin
      @(posedge clk);
      nibbleValid <= 1'b1;
      nibbleErr <= e;
      @(posedge clk);
      nibbleValid <= 1'b0;
    end
  endtask

  task automatic t_regs;
    logic [7:0] ra[4] = '{REG_EXT_ADDR, REG_IRQ_STAT_ADDR,
      REG_IRQ_MASK_ADDR, REG_CTRL_ADDR};
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk(v, 16'h0000);
    end
    wr(REG_EXT_ADDR, 16'hFFFF);
    rd(REG_EXT_ADDR, v);
    chk(v, 16'h00FF);
    wr(REG_EXT_ADDR, 16'h0000);
    wr(8'h40, 16'hFFFF);
    rd(8'h40, v);
    chk(v, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_tally;
    wr(REG_IRQ_MASK_ADDR, 16'h0003);
    @(posedge clk);
    selftestRun <= 1'b1;
    nib(1'b1, 3);
    nib(1'b0, 2);
    rd(REG_EXT_ADDR, v);
    chk(v, 16'h0300);
    @(posedge clk);
    selftestRun <= 1'b0;
    @(posedge clk);
    selftestRun <= 1'b1;
    rd(REG_EXT_ADDR, v);
    chk(v, 16'h0000);
    nib(1'b1, 258);
    rd(REG_EXT_ADDR, v);
    chk(v, 16'hFF00);
    chk(16'(irq), 16'h0001);
    rd(REG_IRQ_STAT_ADDR, v);
    chk(v, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk(16'(irq), 16'h0000);
    selftestRun <= 1'b0;
    $display("test tally done");
  endtask

  task automatic t_pat;
    logic [1:0] pk[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    logic sp[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [15:0] bl[4] = '{16'h0084, 16'h0086, 16'h0002, 16'h0002};
    logic [15:0] g;
    // guard off keeps long bursts whole.
    wr(REG_CTRL_ADDR, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      g = sp[i] ? 16'h012C : 16'h00C8;
      wr(REG_EXT_ADDR, {11'h000, 1'b1, 1'b0, sp[i], pk[i]});
      repeat (800) @(posedge clk);
      chk(burstLen, bl[i]);
      chk(16'(gapLen >= g && gapLen <= g + 16'h0001), 16'h0001);
    end
    // Stop the running pattern so the next test starts from idle.
    wr(REG_EXT_ADDR, 16'h0000);
    wr(REG_CTRL_ADDR, 16'h0000);
    repeat (4) @(posedge clk);
    #1 chk(16'(txEnable), 16'h0000);
    $display("test patterns done");
  endtask

  task automatic t_tone;
    logic p;
    int n;
    n = 0;
    wr(REG_EXT_ADDR, 16'h0013);
    repeat (10) @(posedge clk);
    #1 p = txLine;
    repeat (10) begin
      @(posedge clk);
      #1 if (txLine !== p) n++;
      p = txLine;
    end
    chk(16'(n), 16'h000A);
    chk(16'(txEnable), 16'h0001);
    wr(REG_EXT_ADDR, 16'h0003);
    repeat (4) @(posedge clk);
    #1 chk(16'(txEnable), 16'h0000);
    $display("test tone done");
  endtask

  task automatic t_cont;
    int hi;
    hi = 0;
    wr(REG_CTRL_ADDR, 16'h0001);
    wr(REG_EXT_ADDR, 16'h0020);
    repeat (6) @(posedge clk);
    #1 chk(16'(txEnable), 16'h0000);
    @(posedge clk);
    selftestRun <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (120) begin
      @(posedge clk);
      #1 if (txEnable === 1'b1) hi++;
    end
    chk(16'(hi), 16'h0078);
    wr(REG_CTRL_ADDR, 16'h0000);
    repeat (70) @(posedge clk);
    #1 chk(16'(txEnable), 16'h0000);
    rd(REG_IRQ_STAT_ADDR, v);
    chk(v, 16'h0002);
    selftestRun <= 1'b0;
    wr(REG_EXT_ADDR, 16'h0000);
    $display("test continuous done");
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_tally();
    t_pat();
    t_tone();
    t_cont();
    finish_test();
  end
endmodule // tb_top

`default_nettype wire
